/* File: core/csw_encoder.sv */
// Purpose: Encode the two status bytes closing each command exchange
// Assumes: Requests synchronous to CLOCK; command engine waits for done
// Notes:   Toolkit-only codes fall back to plain codes when unsupported
//
// Functional notes
// - Normal completion with nothing pending gives 90 00.
// - Normal completion with proactive command pending gives 91 and length.
// - Failed download with response data gives 9E and length.
// - Response data waiting for retrieval gives 9F and length.
// - Busy toolkit gives 93 00; later commands still accepted.
// - Retried memory update gives 92 0X; memory failure gives 92 40.
// - File referencing errors give 94 with 00, 02, 04 or 08.
// - Access, remaining-attempt code failure, authentication give 98 04; no code 98 02.
// - Code failure with no attempts left or blocked code gives 98 40.
// - Holder-code state conflict 98 08; invalidation state conflict 98 10.
// - Increase beyond maximum is skipped and gives 98 50.
// - Older cards may give access failure after repeated code failures.
// - Wrong length parameter gives 67 with correct length or 00.
// - Bad parameter 6B, bad instruction 6D, bad class 6E, fault 6F, all 00.
// - Record out of range gives 94 02 instead of 6B.
// - Toolkit-only codes need toolkit support on card and terminal.
// - Proactive code after type 2 search only on the retrieval that follows.
// - Retrieval not directly following its command gives technical fault.
`timescale 1ns/1ps
module csw_encoder
  import csw_pkg::*;
(
  // Clock and reset
  input  wire logic            CLOCK,
  input  wire logic            SYS_RST,
  // Toolkit capability
  input  wire logic            CARD_TOOLKIT,
  input  wire logic            TERM_TOOLKIT,
  // Completion request from the command engine
  input  wire logic            REQ_VALID,
  output      logic            REQ_READY,
  input  wire csw_pkg::csw_req_s REQ,
  // Byte stream towards the terminal, and done pulse to the command engine
  output      logic            TX_VALID,
  input  wire logic            TX_READY,
  output      logic [7:0]      TX_BYTE,
  output      logic            TX_LAST,
  output      logic            DONE
);
  import csw_pkg::*;

  typedef struct packed {
    csw_state_e state;
    logic [7:0] first_status_byte;
    logic [7:0] second_status_byte;
    logic       resp_pending;
    logic       search2_pending;
    logic [7:0] byte_out;
    logic       last;
    logic       done;
  } csw_state_s;

  csw_state_s r;
  csw_state_s next_r;

  logic       toolkit_ok;
  logic [7:0] sb1;
  logic [7:0] sb2;
  logic       take;
  logic       retrieve_ok;

  assign toolkit_ok  = CARD_TOOLKIT & TERM_TOOLKIT;
  assign take        = REQ_VALID & REQ_READY;
  // Retrieval only valid straight after a command that left data
  assign retrieve_ok = r.resp_pending;

  always_comb begin
    sb1 = SB1_NORMAL;
    sb2 = SB2_NONE;
    if (REQ.cmd == CSW_CMD_RETRIEVE && !retrieve_ok) begin
      sb1 = SB1_TECH_FAULT;
      sb2 = SB2_NONE;
    end else begin
      case (REQ.outcome)
        CSW_OK: begin
          // Proactive code suppressed directly after a type 2 search
          if (REQ.proactive && toolkit_ok && REQ.cmd != CSW_CMD_SEARCH2) begin
            sb1 = SB1_PROACTIVE;
            sb2 = REQ.length;
          end else begin
            sb1 = SB1_NORMAL;
            sb2 = SB2_NONE;
          end
        end
        CSW_RESP_READY: begin
          sb1 = SB1_RESP_READY;
          sb2 = REQ.length;
        end
        CSW_DL_ERROR: begin
          // Without toolkit the plain response-ready code is the closest
          sb1 = toolkit_ok ? SB1_DL_ERROR : SB1_RESP_READY;
          sb2 = REQ.length;
        end
        CSW_BUSY: begin
          sb1 = toolkit_ok ? SB1_BUSY : SB1_TECH_FAULT;
          sb2 = SB2_NONE;
        end
        CSW_RETRIED: begin
          sb1 = SB1_MEMORY;
          sb2 = SB2_NONE;
          sb2[RETRY_POS +: RETRY_W] = REQ.retries;
        end
        CSW_MEM_FAIL: begin
          sb1 = SB1_MEMORY;
          sb2 = SB2_MEM_FAIL;
        end
        CSW_NO_FILE: begin
          sb1 = SB1_REFERENCE;
          sb2 = SB2_NO_FILE;
        end
        CSW_OUT_RANGE, CSW_RECORD_RANGE: begin
          sb1 = SB1_REFERENCE;
          sb2 = SB2_OUT_RANGE;
        end
        CSW_NOT_FOUND: begin
          sb1 = SB1_REFERENCE;
          sb2 = SB2_NOT_FOUND;
        end
        CSW_INCONSIST: begin
          sb1 = SB1_REFERENCE;
          sb2 = SB2_INCONSIST;
        end
        CSW_NO_CODE: begin
          sb1 = SB1_SECURITY;
          sb2 = SB2_NO_CODE;
        end
        CSW_ACCESS, CSW_CODE_FAIL_LEFT: begin
          // Older engines may map exhausted counts here too
          sb1 = SB1_SECURITY;
          sb2 = SB2_ACCESS;
        end
        CSW_CODE_FAIL_NONE, CSW_CODE_BLOCKED: begin
          sb1 = SB1_SECURITY;
          sb2 = SB2_BLOCKED;
        end
        CSW_CODE_STATE: begin
          sb1 = SB1_SECURITY;
          sb2 = SB2_CODE_STATE;
        end
        CSW_INVAL_STATE: begin
          sb1 = SB1_SECURITY;
          sb2 = SB2_INVAL_STATE;
        end
        CSW_MAX_VALUE: begin
          sb1 = SB1_SECURITY;
          sb2 = SB2_MAX_VALUE;
        end
        CSW_BAD_LENGTH: begin
          sb1 = SB1_BAD_LENGTH;
          sb2 = REQ.length;
        end
        CSW_BAD_PARAM: begin
          sb1 = SB1_BAD_PARAM;
          sb2 = SB2_NONE;
        end
        CSW_BAD_INSTR: begin
          sb1 = SB1_BAD_INSTR;
          sb2 = SB2_NONE;
        end
        CSW_BAD_CLASS: begin
          sb1 = SB1_BAD_CLASS;
          sb2 = SB2_NONE;
        end
        default: begin
          sb1 = SB1_TECH_FAULT;
          sb2 = SB2_NONE;
        end
      endcase
    end
  end

  always_comb begin
    next_r      = r;
    next_r.done = 1'b0;
    case (r.state)
      CSW_IDLE: begin
        if (take) begin
          next_r.first_status_byte  = sb1;
          next_r.second_status_byte = sb2;
          // Type 2 search holds its proactive note for the retrieval
          if (REQ.cmd == CSW_CMD_RETRIEVE && retrieve_ok && r.search2_pending && toolkit_ok
              && REQ.outcome == CSW_OK) begin
            next_r.first_status_byte  = SB1_PROACTIVE;
            next_r.second_status_byte = REQ.length;
          end
          next_r.resp_pending    = (REQ.outcome == CSW_RESP_READY) ||
                                   (REQ.outcome == CSW_DL_ERROR);
          next_r.search2_pending = (REQ.cmd == CSW_CMD_SEARCH2) && REQ.proactive;
          next_r.byte_out        = sb1;
          next_r.last            = 1'b0;
          next_r.state           = CSW_SEND1;
          if (REQ.cmd == CSW_CMD_RETRIEVE && retrieve_ok && r.search2_pending && toolkit_ok
              && REQ.outcome == CSW_OK) begin
            next_r.byte_out = SB1_PROACTIVE;
          end
        end
      end
      CSW_SEND1: begin
        if (TX_READY) begin
          next_r.byte_out = r.second_status_byte;
          next_r.last     = 1'b1;
          next_r.state    = CSW_SEND2;
        end
      end
      CSW_SEND2: begin
        if (TX_READY) begin
          next_r.last  = 1'b0;
          next_r.done  = 1'b1;
          next_r.state = CSW_IDLE;
        end
      end
      default: next_r.state = CSW_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign REQ_READY = (r.state == CSW_IDLE);
  assign TX_VALID  = (r.state != CSW_IDLE);
  assign TX_BYTE   = r.byte_out;
  assign TX_LAST   = r.last;
  assign DONE      = r.done;

  // Checks
  sequence s_first_sent;
    TX_VALID && TX_READY && !TX_LAST;
  endsequence
  sequence s_second_sent;
    TX_VALID && TX_READY && TX_LAST;
  endsequence
  // Take whose answer is not bent by the retrieval memory
  sequence s_plain_take;
    take && REQ.cmd != CSW_CMD_RETRIEVE;
  endsequence

  AST_ORDER: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    s_first_sent |=> TX_VALID && TX_LAST && TX_BYTE == $past(r.second_status_byte))
    else $error("second status byte not sent after first");
  AST_DONE: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    s_second_sent |=> DONE && REQ_READY)
    else $error("exchange not closed after second byte");
  AST_NORMAL: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    take && REQ.outcome == CSW_OK && !REQ.proactive && REQ.cmd == CSW_CMD_OTHER
    |=> TX_BYTE == SB1_NORMAL && r.second_status_byte == SB2_NONE)
    else $error("normal completion code wrong");
  AST_TOOLKIT: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    TX_VALID && !TX_LAST && !$past(toolkit_ok) && $past(take)
    |-> TX_BYTE != SB1_PROACTIVE && TX_BYTE != SB1_BUSY && TX_BYTE != SB1_DL_ERROR)
    else $error("toolkit code issued without support");
  AST_RETRIEVE: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    take && REQ.cmd == CSW_CMD_RETRIEVE && !r.resp_pending |=> TX_BYTE == SB1_TECH_FAULT)
    else $error("stray retrieval not refused");
  AST_SEARCH2: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    take && REQ.cmd == CSW_CMD_SEARCH2 |=> TX_BYTE != SB1_PROACTIVE)
    else $error("proactive code directly after type 2 search");
  AST_RANGE: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    take && REQ.outcome == CSW_RECORD_RANGE && REQ.cmd != CSW_CMD_RETRIEVE
    |=> TX_BYTE == SB1_REFERENCE && r.second_status_byte == SB2_OUT_RANGE)
    else $error("record range code wrong");
  AST_RETRY: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    take && REQ.outcome == CSW_RETRIED && REQ.cmd != CSW_CMD_RETRIEVE
    |=> TX_BYTE == SB1_MEMORY && r.second_status_byte == {4'h0, $past(REQ.retries)})
    else $error("retry count code wrong");
  AST_MAX: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    take && REQ.outcome == CSW_MAX_VALUE && REQ.cmd != CSW_CMD_RETRIEVE
    |=> TX_BYTE == SB1_SECURITY && r.second_status_byte == SB2_MAX_VALUE)
    else $error("maximum value code wrong");
  AST_PROACTIVE: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    s_plain_take ##0 REQ.outcome == CSW_OK && REQ.proactive && toolkit_ok
      && REQ.cmd != CSW_CMD_SEARCH2
    |=> TX_BYTE == SB1_PROACTIVE && r.second_status_byte == $past(REQ.length))
    else $error("pending proactive code wrong");
  AST_DOWNLOAD: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    s_plain_take ##0 REQ.outcome == CSW_DL_ERROR && toolkit_ok
    |=> TX_BYTE == SB1_DL_ERROR && r.second_status_byte == $past(REQ.length))
    else $error("download error code wrong");
  AST_RESP_DATA: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    s_plain_take ##0 REQ.outcome == CSW_RESP_READY
    |=> TX_BYTE == SB1_RESP_READY && r.second_status_byte == $past(REQ.length))
    else $error("response length code wrong");
  AST_BUSY: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    s_plain_take ##0 REQ.outcome == CSW_BUSY && toolkit_ok
    |=> TX_BYTE == SB1_BUSY && r.second_status_byte == SB2_NONE)
    else $error("busy code wrong");
  AST_BUSY_PLAIN: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    s_plain_take ##0 REQ.outcome == CSW_BUSY && !toolkit_ok
    |=> TX_BYTE == SB1_TECH_FAULT)
    else $error("busy code issued without toolkit support");
  AST_MEMORY: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    s_plain_take ##0 REQ.outcome == CSW_MEM_FAIL
    |=> TX_BYTE == SB1_MEMORY && r.second_status_byte == SB2_MEM_FAIL)
    else $error("memory failure code wrong");
  AST_FILE: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    s_plain_take ##0 REQ.outcome == CSW_NOT_FOUND
    |=> TX_BYTE == SB1_REFERENCE && r.second_status_byte == SB2_NOT_FOUND)
    else $error("file not found code wrong");
  AST_NO_CODE: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    s_plain_take ##0 REQ.outcome == CSW_NO_CODE
    |=> TX_BYTE == SB1_SECURITY && r.second_status_byte == SB2_NO_CODE)
    else $error("no holder code code wrong");
  AST_ACCESS: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    s_plain_take ##0 (REQ.outcome == CSW_ACCESS || REQ.outcome == CSW_CODE_FAIL_LEFT)
    |=> TX_BYTE == SB1_SECURITY && r.second_status_byte == SB2_ACCESS)
    else $error("access failure code wrong");
  AST_BLOCKED: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    s_plain_take ##0 (REQ.outcome == CSW_CODE_FAIL_NONE || REQ.outcome == CSW_CODE_BLOCKED)
    |=> TX_BYTE == SB1_SECURITY && r.second_status_byte == SB2_BLOCKED)
    else $error("blocked code wrong");
  AST_INVAL: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    s_plain_take ##0 REQ.outcome == CSW_INVAL_STATE
    |=> TX_BYTE == SB1_SECURITY && r.second_status_byte == SB2_INVAL_STATE)
    else $error("invalidation state code wrong");
  AST_LENGTH: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    s_plain_take ##0 REQ.outcome == CSW_BAD_LENGTH
    |=> TX_BYTE == SB1_BAD_LENGTH && r.second_status_byte == $past(REQ.length))
    else $error("length parameter code wrong");
  AST_PARAM: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    s_plain_take ##0 REQ.outcome == CSW_BAD_PARAM
    |=> TX_BYTE == SB1_BAD_PARAM && r.second_status_byte == SB2_NONE)
    else $error("parameter error code wrong");
  AST_INSTR: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    s_plain_take ##0 REQ.outcome == CSW_BAD_INSTR
    |=> TX_BYTE == SB1_BAD_INSTR && r.second_status_byte == SB2_NONE)
    else $error("instruction error code wrong");
  AST_LATE_PROACTIVE: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    take && REQ.cmd == CSW_CMD_RETRIEVE && r.resp_pending && r.search2_pending
      && toolkit_ok && REQ.outcome == CSW_OK
    |=> TX_BYTE == SB1_PROACTIVE && r.second_status_byte == $past(REQ.length))
    else $error("proactive code not given on retrieval after type 2 search");
  AST_HOLD: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_BYTE) && $stable(TX_LAST))
    else $error("status byte withdrawn before it was taken");
  AST_DONE_PULSE: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    DONE |=> !DONE)
    else $error("done held longer than one cycle");
  AST_RESET: assert property (@(posedge CLOCK)
    SYS_RST |=> REQ_READY && !TX_VALID && !TX_LAST && !DONE && TX_BYTE == 8'h00)
    else $error("outputs not quiet after reset");

endmodule

/* File: shared/csw_pkg.sv */
// Purpose: Constants and carrier types for the card status word encoder
// Assumes: One 250 MHz clock, synchronous active-high reset
// Notes:   Status byte values are the card's completion codes
package csw_pkg;

  localparam logic [7:0] SB1_NORMAL      = 8'h90;
  localparam logic [7:0] SB1_PROACTIVE   = 8'h91;
  localparam logic [7:0] SB1_MEMORY      = 8'h92;
  localparam logic [7:0] SB1_BUSY        = 8'h93;
  localparam logic [7:0] SB1_REFERENCE   = 8'h94;
  localparam logic [7:0] SB1_SECURITY    = 8'h98;
  localparam logic [7:0] SB1_DL_ERROR    = 8'h9E;
  localparam logic [7:0] SB1_RESP_READY  = 8'h9F;
  localparam logic [7:0] SB1_BAD_LENGTH  = 8'h67;
  localparam logic [7:0] SB1_BAD_PARAM   = 8'h6B;
  localparam logic [7:0] SB1_BAD_INSTR   = 8'h6D;
  localparam logic [7:0] SB1_BAD_CLASS   = 8'h6E;
  localparam logic [7:0] SB1_TECH_FAULT  = 8'h6F;

  localparam logic [7:0] SB2_NONE        = 8'h00;
  localparam logic [7:0] SB2_MEM_FAIL    = 8'h40;
  localparam logic [7:0] SB2_NO_FILE     = 8'h00;
  localparam logic [7:0] SB2_OUT_RANGE   = 8'h02;
  localparam logic [7:0] SB2_NOT_FOUND   = 8'h04;
  localparam logic [7:0] SB2_INCONSIST   = 8'h08;
  localparam logic [7:0] SB2_NO_CODE     = 8'h02;
  localparam logic [7:0] SB2_ACCESS      = 8'h04;
  localparam logic [7:0] SB2_CODE_STATE  = 8'h08;
  localparam logic [7:0] SB2_INVAL_STATE = 8'h10;
  localparam logic [7:0] SB2_BLOCKED     = 8'h40;
  localparam logic [7:0] SB2_MAX_VALUE   = 8'h50;

  localparam int RETRY_POS = 0;
  localparam int RETRY_W   = 4;

  // Outcome classes reported by the command engine
  typedef enum logic [4:0] {
    CSW_OK, CSW_RESP_READY, CSW_DL_ERROR, CSW_BUSY, CSW_RETRIED, CSW_MEM_FAIL,
    CSW_NO_FILE, CSW_OUT_RANGE, CSW_NOT_FOUND, CSW_INCONSIST,
    CSW_NO_CODE, CSW_ACCESS, CSW_CODE_FAIL_LEFT, CSW_CODE_FAIL_NONE,
    CSW_CODE_BLOCKED, CSW_CODE_STATE, CSW_INVAL_STATE, CSW_MAX_VALUE,
    CSW_BAD_LENGTH, CSW_BAD_PARAM, CSW_RECORD_RANGE, CSW_BAD_INSTR,
    CSW_BAD_CLASS, CSW_TECH_FAULT
  } csw_outcome_e;

  typedef enum logic [1:0] {
    CSW_CMD_OTHER, CSW_CMD_SEARCH1, CSW_CMD_SEARCH2, CSW_CMD_RETRIEVE
  } csw_cmd_e;

  typedef struct packed {
    csw_outcome_e outcome;
    csw_cmd_e     cmd;
    logic [7:0]   length;
    logic [3:0]   retries;
    logic         proactive;
  } csw_req_s;

  typedef enum logic [1:0] {CSW_IDLE, CSW_SEND1, CSW_SEND2} csw_state_e;

endpackage

/* File: verification/csw_term_model.sv */
// Purpose: Terminal side that takes the two status bytes of each exchange
// Assumes: One clock; slow makes it accept only every other cycle
// Notes:   Flags a second byte that does not close a pair
`timescale 1ns/1ps
module csw_term_model (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       sys_rst,
  // Pacing
  input  wire logic       slow,
  // Byte stream from the card
  input  wire logic       tx_valid,
  output      logic       tx_ready,
  input  wire logic [7:0] tx_byte,
  input  wire logic       tx_last,
  // Captured status word and byte order flag
  output      logic [7:0] sb1,
  output      logic [7:0] sb2,
  output      logic       order_bad
);
  logic phase;
  logic want_last;

  // Stalls test that each byte stands until taken
  assign tx_ready = !slow || phase;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      phase <= 1'h0;
      want_last <= 1'h0;
      order_bad <= 1'h0;
      sb1 <= 8'h00;
      sb2 <= 8'h00;
    end else begin
      phase <= ~phase;
      if (tx_valid && tx_ready) begin
        if (tx_last != want_last) begin
          order_bad <= 1'h1;
        end
        want_last <= !tx_last;
        if (tx_last) begin
          sb2 <= tx_byte;
        end else begin
          sb1 <= tx_byte;
          // Spoil the old second byte so a lost one is seen
          sb2 <= ~tx_byte;
        end
      end
    end
  end
endmodule

/* File: verification/testbench.sv */
// Purpose: Self-checking bench for the status word encoder
// Assumes: Terminal model takes the bytes; toolkit flags set per case
// Notes:   Table rows first, then sequencing and reset cases
`timescale 1ns/1ps
module testbench;
  import csw_pkg::*;
  typedef struct packed {
    csw_outcome_e o;
    logic [7:0]   len;
    logic         pa;
    logic [1:0]   tk;
    logic [7:0]   e1;
    logic [7:0]   e2;
  } csw_row_s;
  logic       clock;
  logic       sys_rst;
  logic       card_tk;
  logic       term_tk;
  logic       req_valid;
  logic       req_ready;
  csw_req_s   req;
  logic       tx_valid;
  logic       tx_ready;
  logic [7:0] tx_byte;
  logic       tx_last;
  logic       done;
  logic       slow;
  logic [7:0] sb1;
  logic [7:0] sb2;
  logic       order_bad;
  int         fail_count;
  int         total_checks;
  int         cycles;
  csw_row_s   rows [30];

  csw_encoder csw_encoder_i (.CLOCK(clock), .SYS_RST(sys_rst), .CARD_TOOLKIT(card_tk),
    .TERM_TOOLKIT(term_tk), .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ(req),
    .TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_BYTE(tx_byte), .TX_LAST(tx_last),
    .DONE(done));
  csw_term_model csw_term_model_i (.clock(clock), .sys_rst(sys_rst), .slow(slow),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_byte(tx_byte), .tx_last(tx_last),
    .sb1(sb1), .sb2(sb2), .order_bad(order_bad));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic send(input csw_cmd_e c, input csw_row_s r);
    int n;
    n = 0;
    check({7'h0, req_ready}, 8'h01);
    req_valid = 1'h1;
    req = '{r.o, c, r.len, r.len[3:0], r.pa};
    card_tk = r.tk[1];
    term_tk = r.tk[0];
    @(posedge clock);
    #1;
    req_valid = 1'h0;
    check({7'h0, req_ready}, 8'h00);
    while (done !== 1'h1 && n < 40) begin
      @(posedge clock);
      #1;
      n++;
    end
    check({7'h0, done}, 8'h01);
    check(sb1, r.e1);
    check(sb2, r.e2);
    check({7'h0, order_bad}, 8'h00);
  endtask

  initial begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end

  // Cuts a hang well beyond the roughly 140 cycles the run needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      finish_test();
    end
  end

  initial begin
    sys_rst = 1'h1;
    slow = 1'h0;
    card_tk = 1'h0;
    term_tk = 1'h0;
    req_valid = 1'h0;
    req = '0;
    fail_count = 0;
    total_checks = 0;
    cycles = 0;
    rows = '{
      '{CSW_OK, 8'h00, 1'h0, 2'h3, 8'h90, 8'h00},
      '{CSW_OK, 8'h25, 1'h1, 2'h3, 8'h91, 8'h25},
      '{CSW_OK, 8'h25, 1'h1, 2'h2, 8'h90, 8'h00},
      '{CSW_RESP_READY, 8'h1A, 1'h0, 2'h3, 8'h9F, 8'h1A},
      '{CSW_DL_ERROR, 8'h33, 1'h0, 2'h3, 8'h9E, 8'h33},
      '{CSW_DL_ERROR, 8'h33, 1'h0, 2'h1, 8'h9F, 8'h33},
      '{CSW_BUSY, 8'h00, 1'h0, 2'h3, 8'h93, 8'h00},
      '{CSW_BUSY, 8'h00, 1'h0, 2'h0, 8'h6F, 8'h00},
      '{CSW_RETRIED, 8'h07, 1'h0, 2'h3, 8'h92, 8'h07},
      '{CSW_RETRIED, 8'h0F, 1'h0, 2'h3, 8'h92, 8'h0F},
      '{CSW_MEM_FAIL, 8'h00, 1'h0, 2'h3, 8'h92, 8'h40},
      '{CSW_NO_FILE, 8'h00, 1'h0, 2'h3, 8'h94, 8'h00},
      '{CSW_OUT_RANGE, 8'h00, 1'h0, 2'h3, 8'h94, 8'h02},
      '{CSW_NOT_FOUND, 8'h00, 1'h0, 2'h3, 8'h94, 8'h04},
      '{CSW_INCONSIST, 8'h00, 1'h0, 2'h3, 8'h94, 8'h08},
      '{CSW_NO_CODE, 8'h00, 1'h0, 2'h3, 8'h98, 8'h02},
      '{CSW_ACCESS, 8'h00, 1'h0, 2'h3, 8'h98, 8'h04},
      '{CSW_CODE_FAIL_LEFT, 8'h00, 1'h0, 2'h3, 8'h98, 8'h04},
      '{CSW_CODE_FAIL_NONE, 8'h00, 1'h0, 2'h3, 8'h98, 8'h40},
      '{CSW_CODE_BLOCKED, 8'h00, 1'h0, 2'h3, 8'h98, 8'h40},
      '{CSW_CODE_STATE, 8'h00, 1'h0, 2'h3, 8'h98, 8'h08},
      '{CSW_INVAL_STATE, 8'h00, 1'h0, 2'h3, 8'h98, 8'h10},
      '{CSW_MAX_VALUE, 8'h00, 1'h0, 2'h3, 8'h98, 8'h50},
      '{CSW_BAD_LENGTH, 8'h0C, 1'h0, 2'h3, 8'h67, 8'h0C},
      '{CSW_BAD_LENGTH, 8'h00, 1'h0, 2'h3, 8'h67, 8'h00},
      '{CSW_BAD_PARAM, 8'h00, 1'h0, 2'h3, 8'h6B, 8'h00},
      '{CSW_BAD_INSTR, 8'h00, 1'h0, 2'h3, 8'h6D, 8'h00},
      '{CSW_BAD_CLASS, 8'h00, 1'h0, 2'h3, 8'h6E, 8'h00},
      '{CSW_TECH_FAULT, 8'h00, 1'h0, 2'h3, 8'h6F, 8'h00},
      '{CSW_RECORD_RANGE, 8'h00, 1'h0, 2'h3, 8'h94, 8'h02}
    };
    repeat (6) @(posedge clock);
    #1;
    sys_rst = 1'h0;
    foreach (rows[i]) begin
      send(CSW_CMD_OTHER, rows[i]);
    end
    send(CSW_CMD_SEARCH1, '{CSW_OK, 8'h21, 1'h1, 2'h3, 8'h91, 8'h21});
    send(CSW_CMD_SEARCH2, '{CSW_OK, 8'h20, 1'h1, 2'h3, 8'h90, 8'h00});
    send(CSW_CMD_SEARCH2, '{CSW_RESP_READY, 8'h20, 1'h1, 2'h3, 8'h9F, 8'h20});
    send(CSW_CMD_RETRIEVE, '{CSW_OK, 8'h20, 1'h1, 2'h3, 8'h91, 8'h20});
    send(CSW_CMD_OTHER, '{CSW_RESP_READY, 8'h10, 1'h0, 2'h3, 8'h9F, 8'h10});
    send(CSW_CMD_OTHER, '{CSW_OK, 8'h00, 1'h0, 2'h3, 8'h90, 8'h00});
    send(CSW_CMD_RETRIEVE, '{CSW_OK, 8'h10, 1'h0, 2'h3, 8'h6F, 8'h00});
    send(CSW_CMD_OTHER, '{CSW_DL_ERROR, 8'h05, 1'h0, 2'h3, 8'h9E, 8'h05});
    send(CSW_CMD_RETRIEVE, '{CSW_OK, 8'h05, 1'h0, 2'h3, 8'h90, 8'h00});
    slow = 1'h1;
    send(CSW_CMD_OTHER, '{CSW_BUSY, 8'h00, 1'h0, 2'h3, 8'h93, 8'h00});
    send(CSW_CMD_OTHER, '{CSW_OK, 8'h00, 1'h0, 2'h3, 8'h90, 8'h00});
    // Reset lands while the first byte is on offer
    req_valid = 1'h1;
    @(posedge clock);
    #1;
    req_valid = 1'h0;
    sys_rst = 1'h1;
    @(posedge clock);
    #1;
    sys_rst = 1'h0;
    check({4'h0, tx_valid, req_ready, tx_last, done}, 8'h04);
    check(tx_byte, 8'h00);
    send(CSW_CMD_OTHER, '{CSW_OK, 8'h00, 1'h0, 2'h3, 8'h90, 8'h00});
    finish_test();
  end
endmodule
